// File: rtl/mdac_pkg.sv
// Package with subaddresses, field positions and reset values of the mode detect register bank.
package mdac_pkg;
  localparam logic [7:0] ADDR_SCRATCH = 8'h02;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h03;
  localparam logic [7:0] ADDR_SYNC_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FRAME_LINES_LO = 8'h05;
  localparam logic [7:0] ADDR_FRAME_LINES_HI = 8'h06;
  localparam logic [7:0] ADDR_LINE_CLOCKS_LO = 8'h07;
  localparam logic [7:0] ADDR_LINE_CLOCKS_HI = 8'h08;
  localparam logic [7:0] ADDR_REF_LINE_LO = 8'h09;
  localparam logic [7:0] ADDR_REF_LINE_HI = 8'h0a;
  localparam logic [7:0] ADDR_REF_PIXEL_LO = 8'h0b;
  localparam logic [7:0] ADDR_REF_PIXEL_HI = 8'h0c;
  localparam logic [7:0] ADDR_BLACK_THRESHOLD = 8'h0d;
  localparam logic [7:0] ADDR_REF_RED = 8'h0e;
  localparam logic [7:0] ADDR_REF_GREEN = 8'h0f;
  localparam logic [7:0] ADDR_REF_BLUE = 8'h10;
  localparam logic [7:0] ADDR_DARK_LINES = 8'h11;
  localparam logic [7:0] ADDR_DARK_PIXELS_LO = 8'h12;
  localparam logic [7:0] ADDR_DARK_PIXELS_HI = 8'h13;
  localparam logic [7:0] ADDR_LIT_LINES_LO = 8'h14;
  localparam logic [7:0] ADDR_LIT_LINES_HI = 8'h15;
  localparam logic [7:0] ADDR_LIT_PIXELS_LO = 8'h16;
  localparam logic [7:0] ADDR_LIT_PIXELS_HI = 8'h17;
  localparam logic [7:0] ADDR_CONFIG1 = 8'h18;
  localparam logic [7:0] ADDR_CONFIG2 = 8'h19;
  // Configuration register 1 fields.
  localparam int C1_PROC_RESET = 0;
  localparam int C1_MEM_RESET = 1;
  localparam int C1_INPUT_RESET = 2;
  localparam int C1_MEM_INIT = 3;
  localparam int C1_MEM_ABSENT = 4;
  localparam int C1_ONE_CONVERTER = 5;
  localparam int C1_IRQ_ACK = 6;
  // Configuration register 2 fields.
  localparam int C2_OUT_POWER_DOWN = 0;
  localparam int C2_BLANK = 1;
  localparam int C2_DITHER = 2;
  localparam int C2_RGB_STRAIGHT = 3;
  localparam int C2_CLK_FROM_MEM = 4;
  // Values after reset.
  localparam logic [7:0] CONFIG1_RESET = 8'h07;
  localparam logic [7:0] CONFIG2_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'h10;
  // Sync is declared absent after this many clocks without an edge.
  localparam int SYNC_TIMEOUT_CYCLES = 4096;
endpackage : mdac_pkg

// File: rtl/mdac_top.sv
// Mode detection, auto adjustment measurement and configuration register bank.
`timescale 1ns/10ps
`default_nettype none
module mdac_top #(
  parameter int SYNC_TIMEOUT = mdac_pkg::SYNC_TIMEOUT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic irq_event,
  output logic irq_n,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic pix_valid,
  input wire logic [7:0] pix_red,
  input wire logic [7:0] pix_green,
  input wire logic [7:0] pix_blue,
  output logic proc_path_reset,
  output logic mem_path_reset,
  output logic input_path_reset,
  output logic mem_init_start,
  output logic mem_absent,
  output logic single_converter,
  output logic out_power_down,
  output logic blank_screen,
  output logic dither_enable,
  output logic yuv_matrix_enable,
  output logic yuv_clk_from_mem_pin
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic [7:0] rdata;
    logic irq_n;
    logic [7:0] scratch;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic init_pulse;
    logic [10:0] ref_line;
    logic [11:0] ref_pixel;
    logic [7:0] threshold;
    logic hs_prev;
    logic vs_prev;
    logic [12:0] hs_idle;
    logic [12:0] vs_idle;
    logic hs_present;
    logic vs_present;
    logic hs_pol;
    logic vs_pol;
    logic [11:0] clk_cnt;
    logic [11:0] line_clocks;
    logic [10:0] line_cnt;
    logic [10:0] frame_lines;
    logic [11:0] pix_cnt;
    logic [7:0] ref_r;
    logic [7:0] ref_g;
    logic [7:0] ref_b;
    logic line_lit;
    logic dark_run_px;
    logic dark_run_ln;
    logic [8:0] dpix_cnt;
    logic [8:0] dark_pixels;
    logic [11:0] lpix_cnt;
    logic [11:0] lit_pixels;
    logic [7:0] dline_cnt;
    logic [7:0] dark_lines;
    logic [10:0] lline_cnt;
    logic [10:0] lit_lines;
  } mdac_state_s;

  mdac_state_s st_q;
  mdac_state_s st_d;
  logic hs_edge;
  logic vs_edge;
  logic px_black;
  logic px_lit;
  logic [7:0] rd_mux;

  // Active edge of each sync follows the polarity detected for it.
  assign hs_edge = st_q.hs_pol ? (hsync_in & ~st_q.hs_prev) : (~hsync_in & st_q.hs_prev);
  assign vs_edge = st_q.vs_pol ? (vsync_in & ~st_q.vs_prev) : (~vsync_in & st_q.vs_prev);
  // A pixel is black when no component exceeds the threshold colour.
  assign px_black = (pix_red <= st_q.threshold) && (pix_green <= st_q.threshold) &&
                    (pix_blue <= st_q.threshold);
  // A valid pixel above the threshold makes its line non-black.
  assign px_lit = pix_valid & ~px_black;

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Write-only and unmapped subaddresses read as zero.
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      mdac_pkg::ADDR_SCRATCH: rd_mux = st_q.scratch;
      mdac_pkg::ADDR_IRQ_STATUS: rd_mux = {7'h00, st_q.irq_n};
      mdac_pkg::ADDR_SYNC_STATUS: begin
        rd_mux = {4'h0, st_q.vs_pol, st_q.hs_pol, ~st_q.vs_present, ~st_q.hs_present};
      end
      mdac_pkg::ADDR_FRAME_LINES_LO: rd_mux = st_q.frame_lines[7:0];
      mdac_pkg::ADDR_FRAME_LINES_HI: rd_mux = {5'h00, st_q.frame_lines[10:8]};
      mdac_pkg::ADDR_LINE_CLOCKS_LO: rd_mux = st_q.line_clocks[7:0];
      mdac_pkg::ADDR_LINE_CLOCKS_HI: rd_mux = {4'h0, st_q.line_clocks[11:8]};
      mdac_pkg::ADDR_REF_RED: rd_mux = st_q.ref_r;
      mdac_pkg::ADDR_REF_GREEN: rd_mux = st_q.ref_g;
      mdac_pkg::ADDR_REF_BLUE: rd_mux = st_q.ref_b;
      mdac_pkg::ADDR_DARK_LINES: rd_mux = st_q.dark_lines;
      mdac_pkg::ADDR_DARK_PIXELS_LO: rd_mux = st_q.dark_pixels[7:0];
      mdac_pkg::ADDR_DARK_PIXELS_HI: rd_mux = {7'h00, st_q.dark_pixels[8]};
      mdac_pkg::ADDR_LIT_LINES_LO: rd_mux = st_q.lit_lines[7:0];
      mdac_pkg::ADDR_LIT_LINES_HI: rd_mux = {5'h00, st_q.lit_lines[10:8]};
      mdac_pkg::ADDR_LIT_PIXELS_LO: rd_mux = st_q.lit_pixels[7:0];
      mdac_pkg::ADDR_LIT_PIXELS_HI: rd_mux = {4'h0, st_q.lit_pixels[11:8]};
      default: rd_mux = 8'h00;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    st_d.init_pulse = 1'b0;
    st_d.hs_prev = hsync_in;
    st_d.vs_prev = vsync_in;
    if (reg_rd) begin
      st_d.rdata = rd_mux;
    end
    // Register writes; the acknowledge and init bits act only on the write.
    if (reg_wr) begin
      case (reg_addr)
        mdac_pkg::ADDR_SCRATCH: st_d.scratch = reg_wdata;
        mdac_pkg::ADDR_REF_LINE_LO: st_d.ref_line[7:0] = reg_wdata;
        mdac_pkg::ADDR_REF_LINE_HI: st_d.ref_line[10:8] = reg_wdata[2:0];
        mdac_pkg::ADDR_REF_PIXEL_LO: st_d.ref_pixel[7:0] = reg_wdata;
        mdac_pkg::ADDR_REF_PIXEL_HI: st_d.ref_pixel[11:8] = reg_wdata[3:0];
        mdac_pkg::ADDR_BLACK_THRESHOLD: st_d.threshold = reg_wdata;
        mdac_pkg::ADDR_CONFIG1: begin
          st_d.cfg1 = {1'b0, reg_wdata[6:0]};
          st_d.init_pulse = reg_wdata[mdac_pkg::C1_MEM_INIT];
          if (reg_wdata[mdac_pkg::C1_IRQ_ACK]) begin
            st_d.irq_n = 1'b1;
          end
        end
        mdac_pkg::ADDR_CONFIG2: st_d.cfg2 = {3'h0, reg_wdata[4:0]};
        default: st_d.cfg2 = st_q.cfg2;
      endcase
    end
    // A new event beats a simultaneous acknowledge.
    if (irq_event) begin
      st_d.irq_n = 1'b0;
    end
    // Presence: an edge of either level must show up within the timeout.
    // The idle counter runs on to saturation so the polarity sample point is
    // reached even when the timeout is shorter than it.
    if (hsync_in != st_q.hs_prev) begin
      st_d.hs_idle = 13'h0000;
      st_d.hs_present = 1'b1;
    end else begin
      if (st_q.hs_idle != 13'h1fff) begin
        st_d.hs_idle = st_q.hs_idle + 13'h0001;
      end
      if (st_q.hs_idle >= 13'(SYNC_TIMEOUT)) begin
        st_d.hs_present = 1'b0;
      end
    end
    if (vsync_in != st_q.vs_prev) begin
      st_d.vs_idle = 13'h0000;
      st_d.vs_present = 1'b1;
    end else begin
      if (st_q.vs_idle != 13'h1fff) begin
        st_d.vs_idle = st_q.vs_idle + 13'h0001;
      end
      if (st_q.vs_idle >= 13'(SYNC_TIMEOUT)) begin
        st_d.vs_present = 1'b0;
      end
    end
    // Polarity guess: a sync that rests high mostly is a negative pulse.
    if (st_q.hs_idle == 13'h0100) begin
      st_d.hs_pol = ~hsync_in;
    end
    if (st_q.vs_idle == 13'h0100) begin
      st_d.vs_pol = ~vsync_in;
    end
    // Line timing and per-line measurements, frozen while input path is reset.
    if (!st_q.cfg1[mdac_pkg::C1_INPUT_RESET]) begin
      st_d.clk_cnt = st_q.clk_cnt + 12'h001;
      if (pix_valid) begin
        st_d.pix_cnt = st_q.pix_cnt + 12'h001;
        if (!px_black) begin
          st_d.line_lit = 1'b1;
          st_d.dark_run_px = 1'b0;
          st_d.lpix_cnt = st_q.lpix_cnt + 12'h001;
        end else if (st_q.dark_run_px) begin
          st_d.dpix_cnt = st_q.dpix_cnt + 9'h001;
        end
        if (st_q.line_cnt == st_q.ref_line && st_q.pix_cnt == st_q.ref_pixel) begin
          st_d.ref_r = pix_red;
          st_d.ref_g = pix_green;
          st_d.ref_b = pix_blue;
        end
      end
      if (hs_edge) begin
        st_d.line_clocks = st_q.clk_cnt + 12'h001;
        st_d.clk_cnt = 12'h000;
        // The pixel that arrives with the sync edge is the first of the new line.
        st_d.pix_cnt = {11'h000, pix_valid};
        st_d.line_cnt = st_q.line_cnt + 11'h001;
        st_d.line_lit = px_lit;
        st_d.dark_run_px = ~px_lit;
        st_d.dpix_cnt = {8'h00, pix_valid & px_black};
        st_d.lpix_cnt = {11'h000, px_lit};
        if (st_q.line_cnt == st_q.ref_line) begin
          st_d.dark_pixels = st_q.dpix_cnt;
          st_d.lit_pixels = st_q.lpix_cnt;
        end
        if (st_q.line_lit) begin
          st_d.dark_run_ln = 1'b0;
          st_d.lline_cnt = st_q.lline_cnt + 11'h001;
        end else if (st_q.dark_run_ln) begin
          st_d.dline_cnt = st_q.dline_cnt + 8'h01;
        end
      end
      if (vs_edge) begin
        st_d.frame_lines = st_q.line_cnt;
        st_d.line_cnt = 11'h000;
        st_d.dark_lines = st_q.dline_cnt;
        st_d.lit_lines = st_q.lline_cnt;
        st_d.dline_cnt = 8'h00;
        st_d.lline_cnt = 11'h000;
        st_d.dark_run_ln = 1'b1;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= '0;
      st_q.irq_n <= 1'b1;
      st_q.hs_prev <= 1'b1;
      st_q.vs_prev <= 1'b1;
      st_q.cfg1 <= mdac_pkg::CONFIG1_RESET;
      st_q.cfg2 <= mdac_pkg::CONFIG2_RESET;
      st_q.scratch <= mdac_pkg::SCRATCH_RESET;
      st_q.threshold <= mdac_pkg::THRESHOLD_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Outputs come from the state flip-flops; only yuv_matrix_enable passes through an inverter.
  assign reg_rdata = st_q.rdata;
  assign irq_n = st_q.irq_n;
  assign proc_path_reset = st_q.cfg1[mdac_pkg::C1_PROC_RESET];
  assign mem_path_reset = st_q.cfg1[mdac_pkg::C1_MEM_RESET];
  assign input_path_reset = st_q.cfg1[mdac_pkg::C1_INPUT_RESET];
  assign mem_init_start = st_q.init_pulse;
  assign mem_absent = st_q.cfg1[mdac_pkg::C1_MEM_ABSENT];
  assign single_converter = st_q.cfg1[mdac_pkg::C1_ONE_CONVERTER];
  assign out_power_down = st_q.cfg2[mdac_pkg::C2_OUT_POWER_DOWN];
  assign blank_screen = st_q.cfg2[mdac_pkg::C2_BLANK];
  assign dither_enable = st_q.cfg2[mdac_pkg::C2_DITHER];
  assign yuv_matrix_enable = ~st_q.cfg2[mdac_pkg::C2_RGB_STRAIGHT];
  assign yuv_clk_from_mem_pin = st_q.cfg2[mdac_pkg::C2_CLK_FROM_MEM];

endmodule // mdac_top
`default_nettype wire

// File: sim/mdac_top_monitor.sv
// Port-level assertion checker for the mode detect register bank.
`timescale 1ns/10ps
`default_nettype none
module mdac_top_monitor #(
  parameter int SYNC_TIMEOUT = 64
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_event,
  input wire logic irq_n,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic pix_valid,
  input wire logic [7:0] pix_red,
  input wire logic [7:0] pix_green,
  input wire logic [7:0] pix_blue,
  input wire logic proc_path_reset,
  input wire logic mem_path_reset,
  input wire logic input_path_reset,
  input wire logic mem_init_start,
  input wire logic mem_absent,
  input wire logic single_converter,
  input wire logic out_power_down,
  input wire logic blank_screen,
  input wire logic dither_enable,
  input wire logic yuv_matrix_enable,
  input wire logic yuv_clk_from_mem_pin
);
  // Accepted configuration writes and reads, qualified by the clock enable.
  logic wr1, wr2, rd_any;
  assign wr1 = clk_en && reg_wr && (reg_addr == mdac_pkg::ADDR_CONFIG1);
  assign wr2 = clk_en && reg_wr && (reg_addr == mdac_pkg::ADDR_CONFIG2);
  assign rd_any = clk_en && reg_rd;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_irq_set; clk_en && irq_event |=> !irq_n; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not raised");
  property p_irq_ack; wr1 && reg_wdata[6] && !irq_event |=> irq_n; endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("irq not cleared");
  property p_irq_read; rd_any && reg_addr == 8'h03 |=> reg_rdata == {7'h00, $past(irq_n)}; endproperty
  a_irq_read: assert property (p_irq_read) else $error("bad irq status");
  property p_cfg1; wr1 |=> {single_converter, mem_absent, input_path_reset, mem_path_reset,
    proc_path_reset} == {$past(reg_wdata[5:4]), $past(reg_wdata[2:0])}; endproperty
  a_cfg1: assert property (p_cfg1) else $error("bad cfg1 outputs");
  property p_init; wr1 && reg_wdata[3] |=> mem_init_start; endproperty
  a_init: assert property (p_init) else $error("init pulse missing");
  property p_init_src; mem_init_start && $past(clk_en) |-> $past(wr1 && reg_wdata[3]); endproperty
  a_init_src: assert property (p_init_src) else $error("init pulse unasked");
  property p_cfg2; wr2 |=> {yuv_clk_from_mem_pin, !yuv_matrix_enable, dither_enable,
    blank_screen, out_power_down} == $past(reg_wdata[4:0]); endproperty
  a_cfg2: assert property (p_cfg2) else $error("bad cfg2 outputs");
  property p_cfg_hold; !wr1 && !wr2 |=> $stable({proc_path_reset, input_path_reset,
    dither_enable, yuv_matrix_enable}); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed unwritten");
  property p_wo_read; rd_any && reg_addr inside {[8'h09:8'h0d]} |=> reg_rdata == 8'h00; endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read not zero");
endmodule // mdac_top_monitor
bind mdac_top mdac_top_monitor #(.SYNC_TIMEOUT(SYNC_TIMEOUT)) u_monitor (.*);
`default_nettype wire

// File: sim/mdac_host.sv
// Host microcontroller model that issues register accesses to the bank.
`timescale 1ns/10ps
`default_nettype none
module mdac_host (
  input wire logic clk_sys,
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic [7:0] reg_addr,
  output var logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Strobes idle low from time zero.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse, so a stale address is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [7:0] data);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= data;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~data;
  endtask
  // Read data is registered, so it is taken just after the accepting edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] data);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 data = reg_rdata;
  endtask
endmodule // mdac_host
`default_nettype wire

// File: sim/mdac_top_bench.sv
// Self-checking bench for the mode detect register bank.
`timescale 1ns/10ps
`default_nettype none
module mdac_top_bench;
  logic clk_sys, reset, clk_en, irq_event, hsync_in, vsync_in, pix_valid, reg_wr, reg_rd, irq_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pix_red, pix_green, pix_blue, d;
  logic proc_path_reset, mem_path_reset, input_path_reset, mem_init_start, mem_absent;
  logic single_converter, out_power_down, blank_screen, dither_enable, yuv_matrix_enable;
  logic yuv_clk_from_mem_pin;
  int mismatches = 0, checked = 0, m_cfg1, m_cfg2, v, sc = 0;
  bit sync_run = 1'b0, pix_fixed = 1'b0;
  // Model frame: 12 clocks a line, 4 lines a frame, syncs low for two clocks.
  localparam int LN_CLK = 12;
  localparam int FR_LN = 4;
  logic [7:0] wo_list [9] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h18, 8'h19, 8'h00, 8'h1a};
  mdac_top #(.SYNC_TIMEOUT(64)) dut (.*);
  mdac_host host (.*);
  // ****************************************
  // Clock, pixel traffic and checking tasks.
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Random pixels keep the measurement inputs moving while registers are exercised.
  always @(posedge clk_sys) begin
    if (pix_fixed) {pix_valid, pix_red, pix_green, pix_blue} <= {1'b1, 8'h11, 8'h22, 8'h33};
    else {pix_valid, pix_red, pix_green, pix_blue} <= 25'($urandom);
  end
  // Negative syncs; vsync falls mid-line so it never meets an hsync edge.
  always @(posedge clk_sys) begin
    sc <= (sc == FR_LN * LN_CLK - 1) ? 0 : sc + 1;
    hsync_in <= !sync_run || (sc % LN_CLK) >= 2;
    vsync_in <= !sync_run || !(sc == 6 || sc == 7);
  end
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    check(16'(d), 16'(exp));
  endtask
  // The model keeps the written cfg2 byte and bits 5:0 of cfg1; bit 3 of cfg2 is inverted at its port.
  task automatic cfg_check();
    check({6'h00, yuv_clk_from_mem_pin, yuv_matrix_enable, dither_enable, blank_screen,
      out_power_down, single_converter, mem_absent, input_path_reset, mem_path_reset,
      proc_path_reset}, {6'h00, m_cfg2[4], ~m_cfg2[3], m_cfg2[2:0], m_cfg1[5:4], m_cfg1[2:0]});
  endtask
  task automatic do_reset(input int n);
    reset <= 1'b1;
    repeat (n) @(posedge clk_sys);
    reset <= 1'b0;
    m_cfg1 = mdac_pkg::CONFIG1_RESET;
    m_cfg2 = mdac_pkg::CONFIG2_RESET;
  endtask
  // A hang is cut off long after the eight hundred and fifty or so cycles the sequence needs.
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    v = $urandom(32'h85b0a39c);
    clk_en = 1'b1;
    irq_event = 1'b0;
    do_reset(10);
    #1 cfg_check();
    rd_check(mdac_pkg::ADDR_IRQ_STATUS, 8'h01);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      host.wr(mdac_pkg::ADDR_CONFIG1, v[7:0]);
      m_cfg1 = v & 32'h3f;
      #1 check(16'(mem_init_start), 16'(v[3]));
      host.wr(mdac_pkg::ADDR_CONFIG2, v[15:8]);
      m_cfg2 = v[15:8];
      #1 cfg_check();
    end
    repeat (4) begin
      v = $urandom;
      host.wr(mdac_pkg::ADDR_SCRATCH, v[7:0]);
      rd_check(mdac_pkg::ADDR_SCRATCH, v[7:0]);
    end
    // Writes to read-only and unmapped places must leave everything as it was.
    host.wr(mdac_pkg::ADDR_IRQ_STATUS, 8'h00);
    host.wr(8'h1a, 8'hff);
    #1 cfg_check();
    rd_check(mdac_pkg::ADDR_SCRATCH, v[7:0]);
    foreach (wo_list[k]) rd_check(wo_list[k], 8'h00);
    @(posedge clk_sys) irq_event <= 1'b1;
    @(posedge clk_sys) irq_event <= 1'b0;
    rd_check(mdac_pkg::ADDR_IRQ_STATUS, 8'h00);
    host.wr(mdac_pkg::ADDR_CONFIG1, 8'(m_cfg1));
    rd_check(mdac_pkg::ADDR_IRQ_STATUS, 8'h00);
    host.wr(mdac_pkg::ADDR_CONFIG1, 8'(m_cfg1 | 32'h40));
    rd_check(mdac_pkg::ADDR_IRQ_STATUS, 8'h01);
    // Measurements: all-black frames first, then all non-black ones.
    rd_check(mdac_pkg::ADDR_SYNC_STATUS, 8'h03);
    host.wr(mdac_pkg::ADDR_REF_LINE_LO, 8'h02);
    host.wr(mdac_pkg::ADDR_REF_LINE_HI, 8'h00);
    host.wr(mdac_pkg::ADDR_REF_PIXEL_LO, 8'h05);
    host.wr(mdac_pkg::ADDR_REF_PIXEL_HI, 8'h00);
    host.wr(mdac_pkg::ADDR_BLACK_THRESHOLD, 8'h40);
    host.wr(mdac_pkg::ADDR_CONFIG1, 8'h00);
    m_cfg1 = 0;
    sync_run <= 1'b1;
    pix_fixed <= 1'b1;
    repeat (4 * FR_LN * LN_CLK) @(posedge clk_sys);
    rd_check(mdac_pkg::ADDR_SYNC_STATUS, 8'h00);
    rd_check(mdac_pkg::ADDR_FRAME_LINES_LO, 8'(FR_LN));
    rd_check(mdac_pkg::ADDR_FRAME_LINES_HI, 8'h00);
    rd_check(mdac_pkg::ADDR_LINE_CLOCKS_LO, 8'(LN_CLK));
    rd_check(mdac_pkg::ADDR_LINE_CLOCKS_HI, 8'h00);
    rd_check(mdac_pkg::ADDR_REF_RED, 8'h11);
    rd_check(mdac_pkg::ADDR_REF_GREEN, 8'h22);
    rd_check(mdac_pkg::ADDR_REF_BLUE, 8'h33);
    rd_check(mdac_pkg::ADDR_DARK_LINES, 8'(FR_LN));
    rd_check(mdac_pkg::ADDR_DARK_PIXELS_LO, 8'(LN_CLK));
    rd_check(mdac_pkg::ADDR_DARK_PIXELS_HI, 8'h00);
    rd_check(mdac_pkg::ADDR_LIT_LINES_LO, 8'h00);
    rd_check(mdac_pkg::ADDR_LIT_PIXELS_LO, 8'h00);
    host.wr(mdac_pkg::ADDR_BLACK_THRESHOLD, 8'h20);
    repeat (4 * FR_LN * LN_CLK) @(posedge clk_sys);
    rd_check(mdac_pkg::ADDR_DARK_LINES, 8'h00);
    rd_check(mdac_pkg::ADDR_DARK_PIXELS_LO, 8'h00);
    rd_check(mdac_pkg::ADDR_LIT_LINES_LO, 8'(FR_LN));
    rd_check(mdac_pkg::ADDR_LIT_LINES_HI, 8'h00);
    rd_check(mdac_pkg::ADDR_LIT_PIXELS_LO, 8'(LN_CLK));
    rd_check(mdac_pkg::ADDR_LIT_PIXELS_HI, 8'h00);
    // Syncs resting high are lost after the timeout and read as negative.
    sync_run <= 1'b0;
    pix_fixed <= 1'b0;
    repeat (300) @(posedge clk_sys);
    rd_check(mdac_pkg::ADDR_SYNC_STATUS, 8'h03);
    // A write while the clock enable is low must not land.
    @(posedge clk_sys) clk_en <= 1'b0;
    host.wr(mdac_pkg::ADDR_SCRATCH, ~v[7:0]);
    @(posedge clk_sys) clk_en <= 1'b1;
    rd_check(mdac_pkg::ADDR_SCRATCH, v[7:0]);
    do_reset(2);
    #1 cfg_check();
    rd_check(mdac_pkg::ADDR_SCRATCH, mdac_pkg::SCRATCH_RESET);
    finish_test();
  end
endmodule // mdac_top_bench
`default_nettype wire
